/* File: verilog/scrs_pkg.sv */
// Package: constants, modes and register layout for the start-up clock and reset sequencer
`default_nettype none
package scrs_pkg;
   // ==========================================
   // Timing
   // ==========================================
   localparam int unsigned CLK_PERIOD_NS        = 100;
   localparam int unsigned POWER_ON_DELAY_US    = 10;
   localparam int unsigned POWER_UP_DELAY_US    = 64000;
   localparam int unsigned FAIL_MON_DELAY_US    = 100;
   localparam int unsigned OST_CYCLES_DEF       = 1024;
   localparam int unsigned POWER_ON_CYC  = (POWER_ON_DELAY_US * 1000 + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
   localparam int unsigned POWER_UP_CYC  = (POWER_UP_DELAY_US * 1000 + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
   localparam int unsigned FAIL_MON_CYC  = (FAIL_MON_DELAY_US * 1000 + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 20;

   // ==========================================
   // APB register offsets
   // ==========================================
   localparam logic [7:0] OFS_CONFIG  = 8'h00;
   localparam logic [7:0] OFS_OSCCTL  = 8'h04;
   localparam logic [7:0] OFS_RSTCTL  = 8'h08;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h0c;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h10;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h14;

   // Field positions
   localparam int unsigned CFG_FPR_LSB   = 0;
   localparam int unsigned CFG_FOS_LSB   = 8;
   localparam int unsigned CFG_CLOCK_FAIL_MONITOR_BIT  = 12;
   localparam int unsigned CFG_POWER_UP_TIMER_BIT  = 13;
   localparam int unsigned CFG_BOREN_BIT = 14;
   localparam int unsigned OSC_LOCK_BIT  = 5;
   localparam int unsigned OSC_CF_BIT    = 3;
   localparam int unsigned OSC_REQ_BIT   = 0;
   localparam int unsigned RESET_CONTROL_REG_BOR_BIT  = 1;
   localparam int unsigned RESET_CONTROL_REG_POR_BIT  = 0;

   // Reset values
   localparam logic [31:0] CONFIG_RST = 32'h0000_6000;
   localparam logic [1:0]  RESET_CONTROL_REG_RST   = 2'h1;

   // Interrupt events
   localparam int unsigned IRQ_N        = 3;
   localparam int unsigned IRQ_CLKFAIL  = 0;
   localparam int unsigned IRQ_BROWNOUT = 1;
   localparam int unsigned IRQ_RELEASE  = 2;

   // ==========================================
   // Oscillator group and mode
   // ==========================================
   localparam logic [2:0] FOS_FRC  = 3'h0;
   localparam logic [2:0] FOS_LOW_POWER_INTERNAL_RC = 3'h1;
   localparam logic [2:0] FOS_PRI  = 3'h3;
   localparam logic [4:0] FPR_XT       = 5'h04;
   localparam logic [4:0] FPR_XT_PLL4  = 5'h05;
   localparam logic [4:0] FPR_XT_PLL8  = 5'h06;
   localparam logic [4:0] FPR_XT_PLL16 = 5'h07;
   localparam logic [4:0] FPR_HS       = 5'h02;
   localparam logic [4:0] FPR_HS2_4    = 5'h10;
   localparam logic [4:0] FPR_HS2_8    = 5'h11;
   localparam logic [4:0] FPR_HS2_16   = 5'h12;
   localparam logic [4:0] FPR_HS3_4    = 5'h14;
   localparam logic [4:0] FPR_HS3_8    = 5'h15;
   localparam logic [4:0] FPR_HS3_16   = 5'h16;
   localparam logic [4:0] FPR_EC       = 5'h0b;
   localparam logic [4:0] FPR_EXTERNAL_CLOCK_PIN_IO     = 5'h0c;
   localparam logic [4:0] FPR_EC_PLL4  = 5'h0d;
   localparam logic [4:0] FPR_EC_PLL8  = 5'h0e;
   localparam logic [4:0] FPR_EC_PLL16 = 5'h0f;
   localparam logic [4:0] FPR_ERC      = 5'h09;
   localparam logic [4:0] FPR_EXTERNAL_RC_PIN_IO    = 5'h08;

   typedef enum logic [1:0] {SRC_FRC, SRC_LOW_POWER_INTERNAL_RC, SRC_PRIMARY} scrs_src_e;

   typedef struct packed {
      scrs_src_e  src;
      logic       crystal;
      logic       use_pll;
      logic [1:0] pll_mult;    // 0:x4 1:x8 2:x16
      logic [1:0] pre_div;     // 0:/1 1:/2 2:/3
      logic       osc2_fosc4;
   } scrs_clk_sel_s;

   typedef struct packed {
      logic osc_running;
      logic ost_done;
      logic pll_lock;
   } scrs_osc_stat_s;
endpackage : scrs_pkg
`default_nettype wire

/* File: verilog/scrs_mode_decode.sv */
// Decoder from configuration fields to clock path selection
`timescale 1ns/100ps
`default_nettype none
module scrs_mode_decode
   import scrs_pkg::*;
(
   input  wire logic [2:0]    osc_group_select,
   input  wire logic [4:0]    primary_osc_mode,
   output scrs_pkg::scrs_clk_sel_s sel
);
   always_comb begin
      sel = '0;
      sel.src = SRC_PRIMARY;
      if (osc_group_select == FOS_FRC) begin
         sel.src = SRC_FRC;
      end else if (osc_group_select == FOS_LOW_POWER_INTERNAL_RC) begin
         sel.src = SRC_LOW_POWER_INTERNAL_RC;
      end else begin
         unique case (primary_osc_mode)
            FPR_XT, FPR_HS: sel.crystal = 1'b1;
            FPR_XT_PLL4, FPR_XT_PLL8, FPR_XT_PLL16: begin
               sel.crystal  = 1'b1;
               sel.use_pll  = 1'b1;
               sel.pll_mult = primary_osc_mode[1:0] - 2'h1;
            end
            FPR_HS2_4, FPR_HS2_8, FPR_HS2_16: begin
               sel.crystal  = 1'b1;
               sel.use_pll  = 1'b1;
               sel.pre_div  = 2'h1;
               sel.pll_mult = primary_osc_mode[1:0];
            end
            FPR_HS3_4, FPR_HS3_8, FPR_HS3_16: begin
               sel.crystal  = 1'b1;
               sel.use_pll  = 1'b1;
               sel.pre_div  = 2'h2;
               sel.pll_mult = primary_osc_mode[1:0];
            end
            FPR_EC_PLL4, FPR_EC_PLL8, FPR_EC_PLL16: begin
               sel.use_pll  = 1'b1;
               sel.pll_mult = primary_osc_mode[1:0] - 2'h1;
            end
            FPR_ERC: sel.osc2_fosc4 = 1'b1;
            default: sel.crystal = 1'b0;
         endcase
      end
   end
endmodule // scrs_mode_decode
`default_nettype wire

/* File: verilog/scrs_sync.sv */
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module scrs_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } scrs_sync_s;
   scrs_sync_s r_q;
   scrs_sync_s r_d;
   always_comb begin
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end
   assign q = r_q.s2;
endmodule // scrs_sync
`default_nettype wire

/* File: verilog/scrs_top.sv */
// Start-up clock and reset sequencer with APB registers
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module scrs_top
   import scrs_pkg::*;
#(
   parameter int unsigned POWER_UP_CYCLES = POWER_UP_CYC,
   parameter int unsigned OST_CYCLES      = OST_CYCLES_DEF
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             brownout_detect,
   input  wire logic             osc_running_in,
   input  wire logic             pll_lock_in,
   input  wire logic             sleep_or_idle,
   output logic                  internal_reset_n,
   output logic                  clock_fail_trap,
   output logic      [1:0]       sys_clk_src,
   output logic                  pll_enable,
   output logic      [1:0]       pll_mult,
   output logic      [1:0]       pll_pre_div,
   output logic                  osc2_fosc4_en,
   output logic                  irq
);
   import scrs_pkg::*;

   // ==========================================
   // Input synchronisation and mode decode
   // ==========================================
   logic [3:0]     sync_q;
   scrs_clk_sel_s  sel;
   logic           bor_pin, osc_run, pll_lk, sys_clk_seen;

   scrs_sync #(.W(4)) u_sync (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .d       ({brownout_detect, osc_running_in, pll_lock_in, sleep_or_idle}),
      .q       (sync_q)
   );
   assign bor_pin = sync_q[3];
   assign osc_run = sync_q[2];
   assign pll_lk  = sync_q[1];

   typedef enum logic [2:0] {ST_POR, ST_WAIT, ST_RUN, ST_TRAP} scrs_state_e;

   typedef struct packed {
      scrs_state_e    state;
      logic [31:0]    cfg;
      logic [1:0]     reset_control_reg;
      logic           osc_req;
      logic           on_fast_rc;
      logic [CNT_W-1:0] por_cnt;
      logic [CNT_W-1:0] power_up_timer_cnt;
      logic [CNT_W-1:0] ost_cnt;
      logic           bor_prev;
      logic [IRQ_N-1:0] irq_st;
      logic [IRQ_N-1:0] irq_en;
      logic           rst_n;
      logic           trap;
      logic [31:0]    rdata;
      logic           ready;
      logic           slverr;
      logic           irq;
      logic [1:0]     src;
      logic           pll_en;
      logic [1:0]     mult;
      logic [1:0]     prediv;
      logic           fosc4;
   } scrs_state_s;

   scrs_state_s r_q;
   scrs_state_s r_d;

   scrs_mode_decode u_decode (
      .osc_group_select (r_q.cfg[CFG_FOS_LSB +: 3]),
      .primary_osc_mode (r_q.cfg[CFG_FPR_LSB +: 5]),
      .sel              (sel)
   );

   logic clock_fail_monitor_en, power_up_timer_en, bor_en;
   assign clock_fail_monitor_en = r_q.cfg[CFG_CLOCK_FAIL_MONITOR_BIT];
   assign power_up_timer_en = r_q.cfg[CFG_POWER_UP_TIMER_BIT];
   assign bor_en  = r_q.cfg[CFG_BOREN_BIT];

   // Internal and external RC and external clock need no start-up wait
   assign sys_clk_seen = (sel.src != SRC_PRIMARY) || !sel.crystal ? 1'b1 : osc_run;

   // ==========================================
   // Sequencer
   // ==========================================
   logic bor_evt, delays_done, clk_ready, apb_wr, apb_rd;
   logic [IRQ_N-1:0] evt;
   logic [CNT_W-1:0] power_up_timer_target;

   always_comb begin
      // Brown-out detection ignores sleep_or_idle so it keeps working in low power
      bor_evt = bor_en && bor_pin && !r_q.bor_prev;
      apb_wr  = psel && penable && pwrite && !r_q.ready;
      apb_rd  = psel && penable && !pwrite && !r_q.ready;
      // Zero power-up delay on a crystal with the fail monitor on falls back to the monitor delay
      if (power_up_timer_en) begin
         power_up_timer_target = CNT_W'(POWER_UP_CYCLES);
      end else if (sel.crystal && clock_fail_monitor_en) begin
         power_up_timer_target = CNT_W'(FAIL_MON_CYC);
      end else begin
         power_up_timer_target = '0;
      end
      delays_done = (r_q.por_cnt >= CNT_W'(POWER_ON_CYC))
                    && (r_q.power_up_timer_cnt >= power_up_timer_target);
      clk_ready = sys_clk_seen
                  && (!sel.crystal || r_q.ost_cnt >= CNT_W'(OST_CYCLES))
                  && (!sel.use_pll || pll_lk);
      evt = '0;

      r_d          = r_q;
      r_d.bor_prev = bor_pin;
      r_d.ready    = 1'b0;
      r_d.slverr   = 1'b0;

      unique case (r_q.state)
         ST_POR: begin
            r_d.rst_n   = 1'b0;
            r_d.por_cnt = '0;
            r_d.power_up_timer_cnt = '0;
            r_d.ost_cnt = '0;
            r_d.on_fast_rc = 1'b0;
            r_d.trap    = 1'b0;
            r_d.state   = ST_WAIT;
         end
         ST_WAIT: begin
            if (r_q.por_cnt < CNT_W'(POWER_ON_CYC)) r_d.por_cnt = r_q.por_cnt + 1'b1;
            // Power-up delay follows the power-on delay, so the two add up
            if (r_q.por_cnt >= CNT_W'(POWER_ON_CYC) && r_q.power_up_timer_cnt < power_up_timer_target) begin
               r_d.power_up_timer_cnt = r_q.power_up_timer_cnt + 1'b1;
            end
            if (osc_run && r_q.ost_cnt < CNT_W'(OST_CYCLES)) begin
               r_d.ost_cnt = r_q.ost_cnt + 1'b1;
            end
            if (delays_done && clk_ready) begin
               r_d.rst_n = 1'b1;
               r_d.state = ST_RUN;
               evt[IRQ_RELEASE] = 1'b1;
            end else if (delays_done && clock_fail_monitor_en) begin
               r_d.trap       = 1'b1;
               r_d.on_fast_rc = 1'b1;
               r_d.rst_n      = 1'b1;
               r_d.state      = ST_TRAP;
               evt[IRQ_CLKFAIL] = 1'b1;
            end
            // Without the monitor the device just stays held until the clock arrives
         end
         ST_RUN: r_d.state = ST_RUN;
         ST_TRAP: begin
            // Start-up timer keeps running so software can move back to the crystal
            if (osc_run && r_q.ost_cnt < CNT_W'(OST_CYCLES)) begin
               r_d.ost_cnt = r_q.ost_cnt + 1'b1;
            end
            if (apb_wr && paddr == OFS_OSCCTL && pwdata[OSC_REQ_BIT] && clk_ready) begin
               r_d.on_fast_rc = 1'b0;
               r_d.trap       = 1'b0;
               r_d.state      = ST_RUN;
            end
         end
         default: r_d.state = ST_POR;
      endcase

      if (bor_evt) begin
         r_d.state = ST_POR;
         r_d.rst_n = 1'b0;
         r_d.reset_control_reg[RESET_CONTROL_REG_BOR_BIT] = 1'b1;
         evt[IRQ_BROWNOUT] = 1'b1;
      end

      // Clock source, PLL enable and fosc/4 follow the decoded mode unless trapped onto fast RC; mult and pre-divide always follow it
      r_d.src    = r_q.on_fast_rc ? 2'(SRC_FRC) : 2'(sel.src);
      r_d.pll_en = sel.use_pll && !r_q.on_fast_rc;
      r_d.mult   = sel.pll_mult;
      r_d.prediv = sel.pre_div;
      r_d.fosc4  = sel.osc2_fosc4 && !r_q.on_fast_rc;

      // ======================================
      // APB slave, one wait state
      // ======================================
      if (psel && penable && !r_q.ready) begin
         r_d.ready = 1'b1;
      end
      if (apb_wr) begin
         unique case (paddr)
            OFS_CONFIG:  r_d.cfg = pwdata;
            OFS_OSCCTL:  r_d.osc_req = pwdata[OSC_REQ_BIT];
            OFS_RSTCTL:  r_d.reset_control_reg = r_q.reset_control_reg & pwdata[1:0];
            OFS_IRQ_EN:  r_d.irq_en = pwdata[IRQ_N-1:0];
            OFS_IRQ_CLR: r_d.irq_st = r_q.irq_st & ~pwdata[IRQ_N-1:0];
            OFS_IRQ_ST:  r_d.slverr = 1'b0;
            default:     r_d.slverr = 1'b1;
         endcase
      end
      if (bor_evt) r_d.reset_control_reg[RESET_CONTROL_REG_BOR_BIT] = 1'b1;
      r_d.irq_st = r_d.irq_st | evt;
      r_d.irq    = |(r_d.irq_st & r_d.irq_en);
      if (apb_rd) begin
         unique case (paddr)
            OFS_CONFIG: r_d.rdata = r_q.cfg;
            OFS_OSCCTL: r_d.rdata = 32'({pll_lk, 1'b0, r_q.trap, 2'h0, r_q.osc_req});
            OFS_RSTCTL: r_d.rdata = 32'(r_q.reset_control_reg);
            OFS_IRQ_ST: r_d.rdata = 32'(r_q.irq_st);
            OFS_IRQ_EN: r_d.rdata = 32'(r_q.irq_en);
            OFS_IRQ_CLR: r_d.rdata = 32'h0000_0000;
            default: begin
               r_d.rdata  = 32'h0000_0000;
               r_d.slverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         r_q        <= '0;
         r_q.state  <= ST_POR;
         r_q.cfg    <= CONFIG_RST;
         r_q.reset_control_reg   <= RESET_CONTROL_REG_RST;
      end else begin
         r_q <= r_d;
      end
   end

   assign prdata           = r_q.rdata;
   assign pready           = r_q.ready;
   assign pslverr          = r_q.slverr;
   assign internal_reset_n = r_q.rst_n;
   assign clock_fail_trap  = r_q.trap;
   assign sys_clk_src      = r_q.src;
   assign pll_enable       = r_q.pll_en;
   assign pll_mult         = r_q.mult;
   assign pll_pre_div      = r_q.prediv;
   assign osc2_fosc4_en    = r_q.fosc4;
   assign irq              = r_q.irq;

   // ==========================================
   // Checks
   // ==========================================
   AST_BOR_FLAG: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (bor_evt |=> r_q.reset_control_reg[RESET_CONTROL_REG_BOR_BIT] && !internal_reset_n))
      else $error("brown-out flag or reset missing");
   AST_BOR_RESET: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (bor_evt |=> r_q.state == ST_POR))
      else $error("brown-out did not restart sequence");
   AST_TRAP_FRC: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ($rose(clock_fail_trap) |=> sys_clk_src == 2'(SRC_FRC)))
      else $error("trap did not move to fast RC");
   AST_TRAP_COND: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ($rose(clock_fail_trap) |-> $past(clock_fail_monitor_en) && !$past(clk_ready)))
      else $error("trap without cause");
   AST_RELEASE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ($rose(internal_reset_n) |-> $past(delays_done)))
      else $error("reset released early");
   AST_PLL_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (r_q.state == ST_WAIT && sel.use_pll && !pll_lk && !clock_fail_monitor_en
       |=> !internal_reset_n))
      else $error("released without pll lock");
   AST_NOCLK_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (r_q.state == ST_WAIT && !clock_fail_monitor_en && !clk_ready |=> !internal_reset_n))
      else $error("released without clock");
   AST_FOSC4: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (osc2_fosc4_en |-> $past(sel.osc2_fosc4)))
      else $error("fosc4 output in wrong mode");
endmodule // scrs_top
`default_nettype wire

/* File: tb/scrs_osc_model.sv */
// Behavioural crystal oscillator and PLL on the far side of the sequencer
`timescale 1ns/100ps
`default_nettype none
module scrs_osc_model (
   input  wire logic       ref_clk,
   input  wire logic       alive,
   input  wire logic       pll_en,
   input  wire logic [7:0] lock_dly,
   output logic            osc_running,
   output logic            pll_lock
);
   logic [7:0] cnt_q = 8'h00;
   initial pll_lock = 1'b0;
   // ====================
   // Lock needs a running reference and an enabled loop; it is lost with either
   always @(posedge ref_clk) begin
      if (!alive || !pll_en) begin
         cnt_q    <= 8'h00;
         pll_lock <= 1'b0;
      end else if (cnt_q < lock_dly) begin
         cnt_q <= cnt_q + 8'h01;
      end else begin
         pll_lock <= 1'b1;
      end
   end
   assign osc_running = alive;
endmodule // scrs_osc_model
`default_nettype wire

/* File: tb/startup_clock_reset_sequencer_bench.sv */
// Self-checking bench for the start-up clock and reset sequencer
`timescale 1ns/100ps
`default_nettype none
module startup_clock_reset_sequencer_bench;
   import scrs_pkg::*;
   localparam int unsigned PU  = 50;
   localparam int unsigned OSC_STARTUP_TIMER = 8;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, irq;
   logic        brownout_detect = 1'b0;
   logic        sleep_or_idle = 1'b0;
   logic        alive = 1'b1;
   logic [7:0]  lock_dly = 8'h04;
   logic        osc_running_in, pll_lock_in;
   logic        internal_reset_n, clock_fail_trap, pll_enable, osc2_fosc4_en;
   logic [1:0]  sys_clk_src, pll_mult, pll_pre_div;
   logic [31:0] rd;
   logic        err;
   logic [7:0]  e;
   int          n_errors = 0;
   int          compares = 0;
   int          cyc = 0;
   int          n;
   logic [7:0]  modes [21] = '{{FOS_FRC, 5'h00}, {FOS_LOW_POWER_INTERNAL_RC, 5'h00}, {FOS_PRI, FPR_XT},
      {FOS_PRI, FPR_XT_PLL4}, {FOS_PRI, FPR_XT_PLL8}, {FOS_PRI, FPR_XT_PLL16},
      {FOS_PRI, FPR_HS}, {FOS_PRI, FPR_HS2_4}, {FOS_PRI, FPR_HS2_8}, {FOS_PRI, FPR_HS2_16},
      {FOS_PRI, FPR_HS3_4}, {FOS_PRI, FPR_HS3_8}, {FOS_PRI, FPR_HS3_16}, {FOS_PRI, FPR_EC},
      {FOS_PRI, FPR_EXTERNAL_CLOCK_PIN_IO}, {FOS_PRI, FPR_EC_PLL4}, {FOS_PRI, FPR_EC_PLL8},
      {FOS_PRI, FPR_EC_PLL16}, {FOS_PRI, FPR_ERC}, {FOS_PRI, FPR_EXTERNAL_RC_PIN_IO}, {FOS_FRC, FPR_XT}};

   always #50 ref_clk = ~ref_clk;

   scrs_top #(.POWER_UP_CYCLES(PU), .OST_CYCLES(OSC_STARTUP_TIMER)) i_dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .brownout_detect(brownout_detect),
      .osc_running_in(osc_running_in), .pll_lock_in(pll_lock_in),
      .sleep_or_idle(sleep_or_idle), .internal_reset_n(internal_reset_n),
      .clock_fail_trap(clock_fail_trap), .sys_clk_src(sys_clk_src),
      .pll_enable(pll_enable), .pll_mult(pll_mult), .pll_pre_div(pll_pre_div),
      .osc2_fosc4_en(osc2_fosc4_en), .irq(irq));

   scrs_osc_model i_osc (.ref_clk(ref_clk), .alive(alive), .pll_en(pll_enable),
      .lock_dly(lock_dly), .osc_running(osc_running_in), .pll_lock(pll_lock_in));

   // ====================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Called just after a rising edge; the request holds until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wait_rel(input int lim, output int k);
      k = 0;
      while (internal_reset_n !== 1'b1 && k < lim) begin
         @(posedge ref_clk);
         k++;
      end
   endtask

   // Supply monitor dip, in either power state
   task automatic bo;
      brownout_detect <= 1'b1;
      sleep_or_idle   <= 1'($urandom % 2);
      repeat (4) @(posedge ref_clk);
      brownout_detect <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(32'(internal_reset_n), 32'h0);
   endtask

   // Reference model of the clock path: {src, pll, mult, pre-divide, fosc/4}
   function automatic logic [7:0] expo(input logic [7:0] m);
      logic [1:0] src;
      logic       pll;
      logic [1:0] mul;
      logic [1:0] pre;
      src = (m[7:5] == FOS_PRI) ? 2'h2 : (m[7:5] == FOS_LOW_POWER_INTERNAL_RC) ? 2'h1 : 2'h0;
      pll = (src == 2'h2);
      pre = (m[4:2] == 3'h4) ? 2'h1 : (m[4:2] == 3'h5) ? 2'h2 : 2'h0;
      case (m[4:0])
         FPR_XT_PLL4, FPR_HS2_4, FPR_HS3_4, FPR_EC_PLL4: mul = 2'h0;
         FPR_XT_PLL8, FPR_HS2_8, FPR_HS3_8, FPR_EC_PLL8: mul = 2'h1;
         FPR_XT_PLL16, FPR_HS2_16, FPR_HS3_16, FPR_EC_PLL16: mul = 2'h2;
         default: begin
            pll = 1'b0;
            mul = 2'h0;
            pre = 2'h0;
         end
      endcase
      return {src, pll, mul, pre, (src == 2'h2 && m[4:0] == FPR_ERC)};
   endfunction

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         complete_run();
      end
   end

   // ====================
   // Main sequence
   initial begin
      void'($urandom(32'h440f5a76));
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      wait_rel(400, n);
      chk(32'(n >= POWER_ON_CYC + PU && n <= POWER_ON_CYC + PU + 30), 32'h1);
      apb(1'b0, OFS_CONFIG, 32'h0);
      chk(rd, CONFIG_RST);
      apb(1'b0, OFS_RSTCTL, 32'h0);
      chk(rd & 32'h3, 32'(RESET_CONTROL_REG_RST));
      apb(1'b0, 8'h18, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      $display("power-on and register test done");

      foreach (modes[i]) begin
         lock_dly <= 8'($urandom_range(40, 1));
         apb(1'b1, OFS_CONFIG, 32'h4000 | (32'(modes[i][7:5]) << 8) | 32'(modes[i][4:0]));
         bo();
         wait_rel(POWER_ON_CYC + 100, n);
         chk(32'(n >= POWER_ON_CYC - 6 && n < POWER_ON_CYC + 100), 32'h1);
         e = expo(modes[i]);
         chk({sys_clk_src, pll_enable, pll_enable ? pll_mult : 2'h0,
              pll_enable ? pll_pre_div : 2'h0, osc2_fosc4_en}, 32'(e));
         if (e[5]) chk(32'(pll_lock_in), 32'h1);
      end
      apb(1'b0, OFS_RSTCTL, 32'h0);
      chk(rd & 32'h2, 32'h2);
      apb(1'b1, OFS_RSTCTL, 32'h0);
      apb(1'b0, OFS_RSTCTL, 32'h0);
      chk(rd & 32'h3, 32'h0);
      $display("mode table test done");

      alive <= 1'b0;
      apb(1'b1, OFS_CONFIG, 32'h5000 | (32'(FOS_PRI) << 8) | 32'(FPR_XT));
      apb(1'b1, OFS_IRQ_CLR, 32'h7);
      apb(1'b1, OFS_IRQ_EN, 32'h1);
      bo();
      wait_rel(POWER_ON_CYC + FAIL_MON_CYC - 20, n);
      chk(32'(internal_reset_n), 32'h0);
      wait_rel(60, n);
      repeat (2) @(posedge ref_clk);
      chk({clock_fail_trap, internal_reset_n, sys_clk_src}, 32'hc);
      chk(32'(irq), 32'h1);
      apb(1'b0, OFS_OSCCTL, 32'h0);
      chk(rd, 32'h8);
      apb(1'b1, OFS_IRQ_EN, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h0);
      apb(1'b1, OFS_IRQ_EN, 32'h1);
      apb(1'b1, OFS_IRQ_CLR, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h0);
      apb(1'b0, OFS_IRQ_ST, 32'h0);
      chk(rd & 32'h3, 32'h2);
      alive <= 1'b1;
      repeat (OSC_STARTUP_TIMER + 10) @(posedge ref_clk);
      apb(1'b1, OFS_OSCCTL, 32'h1);
      repeat (4) @(posedge ref_clk);
      chk({clock_fail_trap, sys_clk_src}, 32'h2);
      $display("clock failure test done");

      alive <= 1'b0;
      apb(1'b1, OFS_CONFIG, 32'h4000 | (32'(FOS_PRI) << 8) | 32'(FPR_XT));
      bo();
      wait_rel(300, n);
      chk({clock_fail_trap, internal_reset_n}, 32'h0);
      alive <= 1'b1;
      wait_rel(40, n);
      chk(32'(n >= OSC_STARTUP_TIMER && n < 40), 32'h1);
      $display("frozen clock test done");
      complete_run();
   end
endmodule // startup_clock_reset_sequencer_bench
`default_nettype wire
